// ### hdl/lsi_led_status.sv
// Status indicator controller: power and per-channel traffic indicators.
// Assumes all status inputs come from logic on i_clk; no synchronisers needed.
// How it works
// - Power indicator green/yellow; traffic indicator yellow/red per channel.
// - Separate traffic indicator per channel; device error lights every red.
// - Flash: short lit pulse per event; back-to-back events merge.
// - Slow blink: lit and dark phases equal, repeating.
// - Fast blink: equal phases, faster than slow blink.
// - Slow waver: slow blink with second colour instead of dark.
// - Fast waver: colour alternation at fast rate.
// - Running: one colour at a time, power then each channel.
// - Configured and healthy: power steady green.
// - Not configured: power slow-blinks yellow, traffic dark.
// - Configuration error: power waver green/yellow, traffic waver yellow/red.
// - Low supply: power waver green/yellow, traffic slow-blinks yellow.
// - Idle channel: traffic indicator dark.
// - Good frame flashes yellow; error frame flashes red.
// - Firmware update: all traffic indicators fast-blink yellow.
// - Error passive: channel traffic fast-blinks red.
// - Overrun holds red steady until bus-off entry.
// - No script indication by default; running script may override any indicator.
// - Start event on host launch or script launch.
// - Stop event for a running script on host or script halt.
`timescale 1ns/1ps
`include "lsi_map.svh"
module lsi_led_status
  import lsi_pkg::*;
#(
  parameter int unsigned TICK_CYC = `LSI_TICK_NS / `LSI_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_reset_n,
  // Device status
  input  wire logic                                i_usb_configured,
  input  wire logic                                i_fw_cfg_error,
  input  wire logic                                i_power_low,
  input  wire logic                                i_fw_update,
  input  wire logic                                i_device_error,
  input  wire logic                                i_run_pattern,
  // Controller status per channel
  input  wire lsi_can_stat_type [`LSI_NUM_CH-1:0] i_can_stat,
  // Script launch and halt requests
  input  wire logic                                i_host_script_launch_call,
  input  wire logic                                i_script_launch_req,
  input  wire logic                                i_host_script_halt_call,
  input  wire logic                                i_script_halt_req,
  // Script indicator override
  input  wire logic                                i_script_pwr_en,
  input  wire lsi_pat_type                         i_script_pwr_pat,
  input  wire logic [`LSI_NUM_CH-1:0]              i_script_trf_en,
  input  wire lsi_pat_type [`LSI_NUM_CH-1:0]      i_script_trf_pat,
  // Indicators
  output lsi_pwr_led_type                          o_pwr_led,
  output lsi_trf_led_type [`LSI_NUM_CH-1:0]       o_trf_led,
  // Script state and events
  output logic                                     o_script_running,
  output logic                                     o_script_start_evt,
  output logic                                     o_script_stop_evt
);

  localparam int RUN_N  = 2 + 2 * `LSI_NUM_CH;
  localparam int STEP_W = $clog2(RUN_N);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(RUN_N - 1);

  logic              tick;
  logic              slow;
  logic              fast;
  logic              slow_edge;
  logic [STEP_W-1:0] step_q;
  logic [RUN_N-1:0]  run_bits;
  logic              run_act;
  logic              pwr_err;
  logic              script_pwr;
  logic              start_req;
  logic              stop_req;
  lsi_pat_type       pwr_pat;
  lsi_scr_state_type scr_q;

  lsi_timebase #(
    .TICK_CYC (TICK_CYC)
  ) u_timebase (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .o_tick       (tick),
    .o_slow_phase (slow),
    .o_fast_phase (fast),
    .o_slow_edge  (slow_edge)
  );

  // Bit 0 is the first colour, bit 1 the second
  function automatic logic [1:0] pat_eval(input lsi_pat_type pat, input logic s, input logic f);
    logic [1:0] r;
    r = 2'h0;
    case (pat)
      LSI_PAT_ON1:    r = 2'h1;
      LSI_PAT_ON2:    r = 2'h2;
      LSI_PAT_SLOW1:  r = {1'b0, s};
      LSI_PAT_SLOW2:  r = {s, 1'b0};
      LSI_PAT_FAST1:  r = {1'b0, f};
      LSI_PAT_FAST2:  r = {f, 1'b0};
      LSI_PAT_SWAVER: r = {~s, s};
      LSI_PAT_FWAVER: r = {~f, f};
      default:        r = 2'h0;
    endcase
    return r;
  endfunction : pat_eval

  assign pwr_err    = i_fw_cfg_error | i_power_low;
  assign run_act    = i_run_pattern & ~pwr_err;
  assign script_pwr = o_script_running & i_script_pwr_en;
  assign start_req  = i_host_script_launch_call | i_script_launch_req;
  assign stop_req   = i_host_script_halt_call | i_script_halt_req;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !run_act) begin
      step_q <= '0;
    end else if (slow_edge) begin
      step_q <= (step_q == STEP_LAST) ? '0 : step_q + 1'b1;
    end
  end

  assign run_bits = {{(RUN_N-1){1'b0}}, 1'b1} << step_q;

  // Power indicator selection
  always_comb begin
    pwr_pat = LSI_PAT_ON1;
    if (script_pwr) begin
      pwr_pat = i_script_pwr_pat;
    end else if (pwr_err) begin
      pwr_pat = LSI_PAT_SWAVER;
    end else if (!i_usb_configured) begin
      pwr_pat = LSI_PAT_SLOW2;
    end else begin
      pwr_pat = LSI_PAT_ON1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_pwr_led <= `LSI_LED_RST;
    end else if (run_act && !script_pwr) begin
      o_pwr_led <= run_bits[1:0];
    end else begin
      o_pwr_led <= pat_eval(pwr_pat, slow, fast);
    end
  end

  for (genvar c = 0; c < `LSI_NUM_CH; c++) begin : g_ch
    logic [`LSI_CNT_W-1:0] flash_y_q;
    logic [`LSI_CNT_W-1:0] flash_r_q;
    logic                  ovr_q;
    logic                  bus_off_q;
    logic                  scr_c;
    logic                  base_c;
    logic [1:0]            led_q;
    lsi_pat_type           trf_pat;

    assign scr_c  = o_script_running & i_script_trf_en[c];
    assign base_c = ~scr_c & ~run_act & i_usb_configured & ~i_fw_update & ~i_device_error
                    & ~ovr_q & ~i_can_stat[c].err_passive;

    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        bus_off_q <= 1'b0;
      end else begin
        bus_off_q <= i_can_stat[c].bus_off;
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        ovr_q <= 1'b0;
      end else if (i_can_stat[c].overrun) begin
        ovr_q <= 1'b1;
      end else if (i_can_stat[c].bus_off && !bus_off_q) begin
        ovr_q <= 1'b0;
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        flash_y_q <= '0;
        flash_r_q <= '0;
      end else begin
        if (i_can_stat[c].frame_ok) begin
          flash_y_q <= `LSI_FLASH_TICKS;
        end else if (tick && flash_y_q != '0) begin
          flash_y_q <= flash_y_q - 1'b1;
        end
        if (i_can_stat[c].err_frame) begin
          flash_r_q <= `LSI_FLASH_TICKS;
        end else if (tick && flash_r_q != '0) begin
          flash_r_q <= flash_r_q - 1'b1;
        end
      end
    end

    always_comb begin
      trf_pat = LSI_PAT_OFF;
      if (scr_c) begin
        trf_pat = i_script_trf_pat[c];
      end else if (i_fw_cfg_error) begin
        trf_pat = LSI_PAT_SWAVER;
      end else if (i_power_low) begin
        trf_pat = LSI_PAT_SLOW1;
      end else if (!i_usb_configured) begin
        trf_pat = LSI_PAT_OFF;
      end else if (i_fw_update) begin
        trf_pat = LSI_PAT_FAST1;
      end else if (i_device_error || ovr_q) begin
        trf_pat = LSI_PAT_ON2;
      end else if (i_can_stat[c].err_passive) begin
        trf_pat = LSI_PAT_FAST2;
      end else if (flash_r_q != '0) begin
        trf_pat = LSI_PAT_ON2;
      end else if (flash_y_q != '0) begin
        trf_pat = LSI_PAT_ON1;
      end else begin
        trf_pat = LSI_PAT_OFF;
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        led_q <= `LSI_LED_RST;
      end else if (run_act && !scr_c) begin
        led_q <= run_bits[2*c+3 -: 2];
      end else begin
        led_q <= pat_eval(trf_pat, slow, fast);
      end
    end

    assign o_trf_led[c] = led_q;

    a_lowpwr_blink: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_power_low && !i_fw_cfg_error && !scr_c |=> led_q == {1'b0, $past(slow)})
      else $error("traffic not slow-blinking yellow on low supply");
    a_idle_dark: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      base_c && !pwr_err && flash_y_q == '0 && flash_r_q == '0 |=> led_q == 2'h0)
      else $error("idle traffic indicator lit");
    a_flash_yel: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (base_c && !pwr_err && i_can_stat[c].frame_ok && !i_can_stat[c].err_frame && flash_r_q == '0)
      ##1 (base_c && !pwr_err) |=> led_q == 2'h1)
      else $error("frame did not flash yellow");
    a_flash_red: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_can_stat[c].err_frame ##1 (base_c && !pwr_err) |=> led_q == 2'h2)
      else $error("error frame did not flash red");
    a_update_blink: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_fw_update && i_usb_configured && !pwr_err && !scr_c && !run_act |=> led_q == {1'b0, $past(fast)})
      else $error("update not fast-blinking yellow");
    a_passive_blink: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_can_stat[c].err_passive && !scr_c && !run_act && !pwr_err && i_usb_configured && !i_fw_update
      && !i_device_error && !ovr_q |=> led_q == {$past(fast), 1'b0})
      else $error("error passive not fast-blinking red");
    a_ovr_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ovr_q && !(i_can_stat[c].bus_off && !bus_off_q) |=> ovr_q)
      else $error("overrun released before bus-off");
    a_dev_err_red: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_device_error && i_usb_configured && !pwr_err && !i_fw_update && !scr_c && !run_act
      |=> led_q == 2'h2)
      else $error("device error did not light red");
    c_flash_yel: cover property (@(posedge i_clk) disable iff (!i_reset_n)
      i_can_stat[c].frame_ok ##2 led_q == 2'h1);
    c_ovr_release: cover property (@(posedge i_clk) disable iff (!i_reset_n)
      ovr_q ##1 !ovr_q);
  end

  // Script run state
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      scr_q <= LSI_SCR_IDLE;
    end else begin
      case (scr_q)
        LSI_SCR_IDLE: if (start_req) scr_q <= LSI_SCR_RUN;
        LSI_SCR_RUN:  if (stop_req && !start_req) scr_q <= LSI_SCR_IDLE;
        default:      scr_q <= LSI_SCR_IDLE;
      endcase
    end
  end

  assign o_script_running = (scr_q == LSI_SCR_RUN);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_script_start_evt <= 1'b0;
      o_script_stop_evt  <= 1'b0;
    end else begin
      o_script_start_evt <= start_req;
      o_script_stop_evt  <= stop_req & o_script_running;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_pwr_green: assert property (
    i_usb_configured && !pwr_err && !run_act && !script_pwr |=> o_pwr_led.green && !o_pwr_led.yellow)
    else $error("power not steady green");
  a_pwr_wait: assert property (
    !i_usb_configured && !pwr_err && !run_act && !script_pwr
    |=> !o_pwr_led.green && o_pwr_led.yellow == $past(slow))
    else $error("power not slow-blinking yellow");
  a_cfg_waver: assert property (
    i_fw_cfg_error && !script_pwr |=> o_pwr_led.green == $past(slow) && o_pwr_led.yellow != $past(slow))
    else $error("power not wavering on config error");
  a_run_onehot: assert property (
    run_act && !o_script_running |=> $onehot({o_pwr_led, o_trf_led}))
    else $error("running pattern lit more than one colour");
  a_script_pwr: assert property (
    script_pwr |=> o_pwr_led == pat_eval($past(i_script_pwr_pat), $past(slow), $past(fast)))
    else $error("script override not applied");
  a_start_evt: assert property (
    start_req |=> o_script_start_evt && o_script_running)
    else $error("start event missing");
  a_stop_evt: assert property (
    stop_req && !start_req && o_script_running |=> o_script_stop_evt && !o_script_running)
    else $error("stop event missing");
  a_no_stop_idle: assert property (
    !o_script_running |=> !o_script_stop_evt)
    else $error("stop event without running script");
  c_run_wrap: cover property (step_q == STEP_LAST ##1 step_q == '0 && run_act);
  c_script_stop: cover property (o_script_start_evt ##[1:20] o_script_stop_evt);

endmodule : lsi_led_status

// ### hdl/lsi_map.svh
// Constants for the status indicator block: channel count, timing, reset values.
// Assumes a 200 MHz system clock; all counts derive from the tick period.
`ifndef LSI_MAP_SVH
`define LSI_MAP_SVH

`define LSI_NUM_CH        1
`define LSI_CLK_PERIOD_NS 5
`define LSI_TICK_NS       1000000
`define LSI_CNT_W         10
`define LSI_FLASH_TICKS   10'h014
`define LSI_SLOW_TICKS    10'h1f4
`define LSI_FAST_TICKS    10'h07d
`define LSI_LED_RST       2'h0

`endif

// ### hdl/lsi_pkg.sv
// Types shared by the status indicator block.
// Assumes lsi_map.svh is compiled alongside for the constants.
package lsi_pkg;

  typedef struct packed {
    logic yellow;
    logic green;
  } lsi_pwr_led_type;

  typedef struct packed {
    logic red;
    logic yellow;
  } lsi_trf_led_type;

  typedef struct packed {
    logic frame_ok;
    logic err_frame;
    logic err_passive;
    logic overrun;
    logic bus_off;
  } lsi_can_stat_type;

  typedef enum logic [3:0] {
    LSI_PAT_OFF,
    LSI_PAT_ON1,
    LSI_PAT_ON2,
    LSI_PAT_SLOW1,
    LSI_PAT_FAST1,
    LSI_PAT_SLOW2,
    LSI_PAT_FAST2,
    LSI_PAT_SWAVER,
    LSI_PAT_FWAVER
  } lsi_pat_type;

  typedef enum logic {
    LSI_SCR_IDLE,
    LSI_SCR_RUN
  } lsi_scr_state_type;

endpackage : lsi_pkg

// ### hdl/lsi_timebase.sv
// Prescaled time base: tick pulse, slow and fast blink phases, slow step pulse.
// Assumes one synchronous system clock and active-low synchronous reset.
`timescale 1ns/1ps
`include "lsi_map.svh"
module lsi_timebase
  import lsi_pkg::*;
#(
  parameter int unsigned TICK_CYC = 200000
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // Timing outputs
  output logic      o_tick,
  output logic      o_slow_phase,
  output logic      o_fast_phase,
  output logic      o_slow_edge
);

  localparam int TW = $clog2(TICK_CYC);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

  logic [TW-1:0]        tick_cnt_q;
  logic [`LSI_CNT_W-1:0] slow_cnt_q;
  logic [`LSI_CNT_W-1:0] fast_cnt_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      tick_cnt_q <= '0;
      o_tick     <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
      o_tick     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      o_tick     <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      slow_cnt_q   <= '0;
      o_slow_phase <= 1'b0;
      o_slow_edge  <= 1'b0;
    end else if (o_tick && slow_cnt_q == `LSI_SLOW_TICKS - 10'h001) begin
      slow_cnt_q   <= '0;
      o_slow_phase <= ~o_slow_phase;
      o_slow_edge  <= 1'b1;
    end else begin
      slow_cnt_q   <= o_tick ? slow_cnt_q + 1'b1 : slow_cnt_q;
      o_slow_edge  <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      fast_cnt_q   <= '0;
      o_fast_phase <= 1'b0;
    end else if (o_tick && fast_cnt_q == `LSI_FAST_TICKS - 10'h001) begin
      fast_cnt_q   <= '0;
      o_fast_phase <= ~o_fast_phase;
    end else if (o_tick) begin
      fast_cnt_q   <= fast_cnt_q + 1'b1;
    end
  end

  default clocking tb_cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_slow_edge_toggle: assert property (o_slow_edge |-> o_slow_phase != $past(o_slow_phase))
    else $error("slow phase did not toggle on step");
  a_slow_phase_hold: assert property (!o_slow_edge |-> o_slow_phase == $past(o_slow_phase))
    else $error("slow phase changed without step");

endmodule : lsi_timebase

// ### tb/lsi_led_viewer.sv
// Observer of one dual-colour indicator as the user sees it.
// Assumes the indicator value is settled at each rising clock edge.
`timescale 1ns/1ps
module lsi_led_viewer (
  // Clock
  input  wire logic       i_clk,
  // Indicator seen
  input  wire logic [1:0] i_led,
  // Observations
  output int unsigned     o_last_run,
  output int unsigned     o_changes
);
  logic [1:0]  prev_q = 2'h0;
  int unsigned cnt_q  = 0;

  initial begin
    o_last_run = 0;
    o_changes  = 0;
  end

  // Length of the last steady run between colour changes
  always @(posedge i_clk) begin
    if (i_led !== prev_q) begin
      o_last_run <= cnt_q;
      cnt_q      <= 1;
      o_changes  <= o_changes + 1;
    end else begin
      cnt_q <= cnt_q + 1;
    end
    prev_q <= i_led;
  end
endmodule : lsi_led_viewer

// ### tb/lsi_led_status_tb.sv
// Self-checking bench for the status indicator controller.
// Assumes the indicator observer model and a shortened tick of 4 cycles.
`timescale 1ns/1ps
`include "lsi_map.svh"
module lsi_led_status_tb
  import lsi_pkg::*;
;
  localparam int TICK  = 4;
  localparam int SLOW  = `LSI_SLOW_TICKS * TICK;
  localparam int FAST  = `LSI_FAST_TICKS * TICK;
  localparam int FLASH = `LSI_FLASH_TICKS * TICK;
  localparam int LIMIT = 100000;

  logic                   i_clk = 1'b0, i_reset_n = 1'b0;
  logic                   cfg = 1'b0, cerr = 1'b0, plow = 1'b0, fwu = 1'b0, derr = 1'b0, runp = 1'b0;
  logic                   fo = 1'b0, ef = 1'b0, ep = 1'b0, ov = 1'b0, bo = 1'b0;
  logic                   hl = 1'b0, sl = 1'b0, hh = 1'b0, sh = 1'b0, spe = 1'b0;
  logic [0:0]             ste = 1'b0;
  lsi_pat_type            spp = LSI_PAT_OFF;
  lsi_pat_type [0:0]      stp;
  lsi_can_stat_type [0:0] can;
  lsi_pwr_led_type        power_indicator_label;
  lsi_trf_led_type [0:0]  trf;
  logic                   run_o, sev, pev;
  int unsigned            prun, pchg, trun, tchg;
  int                     err_count = 0, comparisons = 0, cyc = 0;

  assign can[0] = '{frame_ok: fo, err_frame: ef, err_passive: ep, overrun: ov, bus_off: bo};

  initial forever #2.5 i_clk = ~i_clk;

  lsi_led_status #(.TICK_CYC(TICK)) i_lsi_led_status (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_usb_configured(cfg), .i_fw_cfg_error(cerr),
    .i_power_low(plow), .i_fw_update(fwu), .i_device_error(derr), .i_run_pattern(runp),
    .i_can_stat(can), .i_host_script_launch_call(hl), .i_script_launch_req(sl),
    .i_host_script_halt_call(hh), .i_script_halt_req(sh), .i_script_pwr_en(spe),
    .i_script_pwr_pat(spp), .i_script_trf_en(ste), .i_script_trf_pat(stp), .o_pwr_led(power_indicator_label),
    .o_trf_led(trf), .o_script_running(run_o), .o_script_start_evt(sev), .o_script_stop_evt(pev));

  lsi_led_viewer i_view_pwr (.i_clk(i_clk), .i_led(power_indicator_label), .o_last_run(prun), .o_changes(pchg));
  lsi_led_viewer i_view_trf (.i_clk(i_clk), .i_led(trf), .o_last_run(trun), .o_changes(tchg));

  task automatic stop_test;
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wt

  task automatic pulse(ref logic s);
    s = 1'b1;
    wt(1);
    s = 1'b0;
  endtask : pulse

  // Waits for three colour changes and returns the last steady run
  task automatic measure(input bit t, output int run);
    int unsigned c0;
    int          n;
    c0 = t ? tchg : pchg;
    n  = 0;
    while ((t ? tchg : pchg) - c0 < 3 && n < 4 * SLOW) begin
      wt(1);
      n++;
    end
    chk(n < 4 * SLOW, 1);
    run = t ? trun : prun;
  endtask : measure

  task automatic evt(output int ns, output int np);
    ns = sev;
    np = pev;
    repeat (3) begin
      wt(1);
      ns += sev;
      np += pev;
    end
  endtask : evt

  task automatic nextv(inout logic [3:0] v);
    int n;
    n = 0;
    while ({trf, power_indicator_label} === v && n < 3 * SLOW) begin
      wt(1);
      n++;
    end
    v = {trf, power_indicator_label};
  endtask : nextv

  function automatic logic [3:0] succ(input logic [3:0] v);
    return (v == 4'h8) ? 4'h1 : v << 1;
  endfunction : succ

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    int          run, ns, np, gap;
    logic [3:0]  v;
    logic [3:0]  exp_v;
    lsi_pat_type p;
    stp[0] = LSI_PAT_OFF;
    void'($urandom(32'haabb));
    wt(10);
    chk({trf, power_indicator_label, run_o, sev, pev}, 7'h00);
    i_reset_n = 1'b1;
    measure(0, run);
    chk(run, SLOW);
    chk({trf, power_indicator_label.green}, 3'h0);
    cfg = 1'b1;
    wt(3);
    chk(power_indicator_label, 2'h1);
    chk(trf, 2'h0);
    pulse(fo);
    wt(2);
    chk(trf, 2'h1);
    wt(FLASH - 20);
    chk(trf, 2'h1);
    wt(40);
    chk(trf, 2'h0);
    pulse(fo);
    wt(2);
    repeat (20) begin
      pulse(fo);
      gap = $urandom_range(5, FLASH - 20);
      repeat (gap) begin
        wt(1);
        chk(trf, 2'h1);
      end
    end
    wt(FLASH + 20);
    pulse(ef);
    wt(2);
    chk(trf, 2'h2);
    wt(FLASH + 20);
    ep = 1'b1;
    measure(1, run);
    chk(run, FAST);
    chk(trf[0].yellow, 1'b0);
    ep  = 1'b0;
    fwu = 1'b1;
    measure(1, run);
    chk(run, FAST);
    chk(trf[0].red, 1'b0);
    fwu = 1'b0;
    pulse(ov);
    wt(2);
    chk(trf, 2'h2);
    repeat (30) begin
      pulse(fo);
      wt(99);
    end
    chk(trf, 2'h2);
    bo = 1'b1;
    wt(3);
    chk(trf, 2'h0);
    bo   = 1'b0;
    derr = 1'b1;
    pulse(fo);
    wt(3);
    chk(trf, 2'h2);
    derr = 1'b0;
    wt(FLASH + 20);
    cerr = 1'b1;
    measure(0, run);
    chk(run, SLOW);
    chk(power_indicator_label == 2'h1 || power_indicator_label == 2'h2, 1'b1);
    measure(1, run);
    chk(run, SLOW);
    chk(trf == 2'h1 || trf == 2'h2, 1'b1);
    cerr = 1'b0;
    plow = 1'b1;
    measure(0, run);
    chk(run, SLOW);
    chk(power_indicator_label == 2'h1 || power_indicator_label == 2'h2, 1'b1);
    measure(1, run);
    chk(run, SLOW);
    chk(trf[0].red, 1'b0);
    plow = 1'b0;
    runp = 1'b1;
    wt(3);
    v = {trf, power_indicator_label};
    chk(v, 4'h1);
    repeat (5) begin
      exp_v = succ(v);
      nextv(v);
      chk(v, exp_v);
    end
    runp = 1'b0;
    spe  = 1'b1;
    spp  = LSI_PAT_ON2;
    pulse(sh);
    evt(ns, np);
    chk(np, 0);
    chk(run_o, 1'b0);
    chk(power_indicator_label, 2'h1);
    pulse(hl);
    evt(ns, np);
    chk(ns, 1);
    chk({run_o, power_indicator_label}, 3'h6);
    pulse(sl);
    evt(ns, np);
    chk(ns, 1);
    ste = 1'b1;
    for (int i = 0; i < 3; i++) begin
      p      = lsi_pat_type'(i);
      stp[0] = p;
      wt(3);
      chk(trf, i);
    end
    stp[0] = LSI_PAT_FWAVER;
    measure(1, run);
    chk(run, FAST);
    chk(trf == 2'h1 || trf == 2'h2, 1'b1);
    pulse(hh);
    evt(ns, np);
    chk(np, 1);
    chk(run_o, 1'b0);
    chk(power_indicator_label, 2'h1);
    pulse(sl);
    evt(ns, np);
    chk(ns, 1);
    pulse(sh);
    evt(ns, np);
    chk(np, 1);
    chk(run_o, 1'b0);
    // Second reset in mid-run clears every output
    i_reset_n = 1'b0;
    wt(2);
    chk({trf, power_indicator_label, run_o, sev, pev}, 7'h00);
    i_reset_n = 1'b1;
    wt(3);
    chk(power_indicator_label, 2'h1);
    stop_test();
  end
endmodule : lsi_led_status_tb
